//--- core/system_status_registers.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
// Contract
// [RULE_01] Input voltage in status1 bits 31..16, tenths of a volt.
// [RULE_02] Decoded speed command in status1 bits 15..1, 32767 is full scale.
// [RULE_03] Status1 bit 0 is one when serial mode entered by pin sequence.
// [RULE_04] Control state code in status2 bits 31..28.
// [RULE_05] Status2 bit 17 is one when self test failed, zero on pass.
// [RULE_06] Electrical motor speed in status2 bits 15..0, tenths of hertz.
// [RULE_07] Status1 at index E4h, read-only word, clears to zero on reset.
// [RULE_08] Status2 at EAh and status3 at ECh, read-only, zero on reset.
// [RULE_09] Reserved status2 bits read zero; writes to status words ignored.
module system_status_registers
    import sys_status_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [VOLT_W-1:0] input_voltage_reading,
    input wire logic [SPEED_CMD_W-1:0] speed_command,
    input wire logic serial_entry_by_pins,
    input wire logic [STATE_W-1:0] control_state,
    input wire logic self_test_fail_flag,
    input wire logic [MOTOR_SPEED_W-1:0] motor_speed,
    input wire logic [DATA_W-1:0] current_power_word,
    output logic irq
);

    apb_state_t apb_q;
    apb_state_t apb_d;

    logic [VOLT_W-1:0] volt_q;
    logic [SPEED_CMD_W-1:0] speed_cmd_q;
    logic [0:0] serial_entry_q;
    logic [STATE_W-1:0] state_q;
    logic [STATE_W-1:0] state_d;
    logic state_known;
    logic [0:0] self_test_q;
    logic [MOTOR_SPEED_W-1:0] motor_speed_q;
    logic [DATA_W-1:0] current_power_q;

    logic [DATA_W-1:0] status1_word;
    logic [DATA_W-1:0] status2_word;
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] irq_status_q;
    logic [EV_W-1:0] irq_enable_q;

    logic [WORD_W-1:0] word_addr;
    logic aligned;
    logic hit_status1;
    logic hit_status2;
    logic hit_status3;
    logic hit_irq_status;
    logic hit_irq_enable;
    logic hit_irq_clear;
    logic mapped;
    logic setup_phase;
    logic access_done;
    logic enable_we;
    logic clear_we;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] prdata_q;
    logic err_d;
    logic err_q;

    // [RULE_04] documented state codes
    always_comb begin
        state_known = 1'b0;
        case (ctrl_state_t'(control_state))
            ST_SYSTEM_IDLE: begin
                state_known = 1'b1;
            end
            ST_START: begin
                state_known = 1'b1;
            end
            ST_RUN: begin
                state_known = 1'b1;
            end
            ST_INIT: begin
                state_known = 1'b1;
            end
            ST_INITIAL_POSITION_DETECT_PHASE: begin
                state_known = 1'b1;
            end
            ST_ALIGN: begin
                state_known = 1'b1;
            end
            ST_MOTOR_IDLE: begin
                state_known = 1'b1;
            end
            ST_STOP: begin
                state_known = 1'b1;
            end
            ST_FAULT: begin
                state_known = 1'b1;
            end
            ST_DIRECTION: begin
                state_known = 1'b1;
            end
            ST_SENSOR_ALIGN_PHASE: begin
                state_known = 1'b1;
            end
            ST_COASTING_PHASE: begin
                state_known = 1'b1;
            end
            ST_BRAKING_PHASE: begin
                state_known = 1'b1;
            end
            ST_NOT_APPLICABLE: begin
                state_known = 1'b1;
            end
            ST_CODE_B: begin
                state_known = 1'b0;
            end
            ST_CODE_E: begin
                state_known = 1'b0;
            end
            default: begin
                state_known = 1'b0;
            end
        endcase
    end

    // Codes outside the documented set are shown as not applicable
    assign state_d = state_known ? control_state : ST_NOT_APPLICABLE;

    // [RULE_01] voltage field capture
    field_reg #(
        .W(VOLT_W)
    ) u_volt (
        .pclk(pclk),
        .presetn(presetn),
        .load(ce),
        .d(input_voltage_reading),
        .q(volt_q)
    );

    // [RULE_02] speed command capture
    field_reg #(
        .W(SPEED_CMD_W)
    ) u_speed_cmd (
        .pclk(pclk),
        .presetn(presetn),
        .load(ce),
        .d(speed_command),
        .q(speed_cmd_q)
    );

    // [RULE_03] serial entry capture
    field_reg #(
        .W(1)
    ) u_serial_entry (
        .pclk(pclk),
        .presetn(presetn),
        .load(ce),
        .d(serial_entry_by_pins),
        .q(serial_entry_q)
    );

    // [RULE_04] control state capture
    field_reg #(
        .W(STATE_W)
    ) u_state (
        .pclk(pclk),
        .presetn(presetn),
        .load(ce),
        .d(state_d),
        .q(state_q)
    );

    // [RULE_05] self test flag capture
    field_reg #(
        .W(1)
    ) u_self_test (
        .pclk(pclk),
        .presetn(presetn),
        .load(ce),
        .d(self_test_fail_flag),
        .q(self_test_q)
    );

    // [RULE_06] motor speed capture
    field_reg #(
        .W(MOTOR_SPEED_W)
    ) u_motor_speed (
        .pclk(pclk),
        .presetn(presetn),
        .load(ce),
        .d(motor_speed),
        .q(motor_speed_q)
    );

    // [RULE_08] third status word capture
    field_reg #(
        .W(DATA_W)
    ) u_current_power (
        .pclk(pclk),
        .presetn(presetn),
        .load(ce),
        .d(current_power_word),
        .q(current_power_q)
    );

    // [RULE_01] [RULE_02] [RULE_03] status1 packing
    always_comb begin
        status1_word = STATUS_RESET;
        status1_word[VOLT_LSB +: VOLT_W] = volt_q;
        status1_word[SPEED_CMD_LSB +: SPEED_CMD_W] = speed_cmd_q;
        status1_word[SERIAL_ENTRY_BIT] = serial_entry_q[0];
    end

    // [RULE_04] [RULE_05] [RULE_06] status2 packing
    // [RULE_09] reserved bits stay zero
    always_comb begin
        status2_word = STATUS_RESET;
        status2_word[STATE_LSB +: STATE_W] = state_q;
        status2_word[SELF_TEST_BIT] = self_test_q[0];
        status2_word[MOTOR_SPEED_LSB +: MOTOR_SPEED_W] = motor_speed_q;
    end

    // Events compare the incoming value with the held one; invalid state is decoded from the incoming code alone
    always_comb begin
        events = '0;
        events[EV_SERIAL_ENTRY] = serial_entry_by_pins & ~serial_entry_q[0];
        events[EV_SELF_TEST_FAIL] = self_test_fail_flag & ~self_test_q[0];
        events[EV_STATE_CHANGE] = (state_d != state_q);
        events[EV_FAULT_ENTRY] = (state_d == ST_FAULT) && (state_q != ST_FAULT);
        events[EV_INVALID_STATE] = !state_known;
    end

    // Address decode
    assign word_addr = paddr[ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign hit_status1 = aligned && (word_addr == WORD_W'(STATUS1_IDX));
    assign hit_status2 = aligned && (word_addr == WORD_W'(STATUS2_IDX));
    assign hit_status3 = aligned && (word_addr == WORD_W'(STATUS3_IDX));
    assign hit_irq_status = aligned && (word_addr == WORD_W'(IRQ_STATUS_IDX));
    assign hit_irq_enable = aligned && (word_addr == WORD_W'(IRQ_ENABLE_IDX));
    assign hit_irq_clear = aligned && (word_addr == WORD_W'(IRQ_CLEAR_IDX));
    assign mapped = hit_status1 | hit_status2 | hit_status3 | hit_irq_status | hit_irq_enable | hit_irq_clear;

    assign setup_phase = psel && !penable;
    // Writes land only in an access that followed a setup
    assign access_done = psel && penable && ce && (apb_q == APB_SETUP);

    always_comb begin
        case (apb_q)
            APB_IDLE: begin
                apb_d = setup_phase ? APB_SETUP : APB_IDLE;
            end
            APB_SETUP: begin
                apb_d = (psel && penable) ? APB_ACCESS : (setup_phase ? APB_SETUP : APB_IDLE);
            end
            APB_ACCESS: begin
                apb_d = setup_phase ? APB_SETUP : APB_IDLE;
            end
            default: begin
                apb_d = APB_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_q <= APB_IDLE;
        end else if (ce) begin
            apb_q <= apb_d;
        end
    end

    // [RULE_07] [RULE_08] read mux at fixed indices
    always_comb begin
        rdata_d = STATUS_RESET;
        if (!pwrite) begin
            if (hit_status1) begin
                rdata_d = status1_word;
            end else if (hit_status2) begin
                rdata_d = status2_word;
            end else if (hit_status3) begin
                rdata_d = current_power_q;
            end else if (hit_irq_status) begin
                rdata_d = {{(DATA_W-EV_W){1'b0}}, irq_status_q};
            end else if (hit_irq_enable) begin
                rdata_d = {{(DATA_W-EV_W){1'b0}}, irq_enable_q};
            end else begin
                rdata_d = STATUS_RESET;
            end
        end
    end

    // Unmapped, unaligned, read of clear register; a write of a status word is not an error
    always_comb begin
        err_d = !mapped;
        if (!pwrite && hit_irq_clear) begin
            err_d = 1'b1;
        end
        if (pwrite && (hit_status1 || hit_status2 || hit_status3 || hit_irq_status)) begin
            err_d = 1'b0;
        end
    end

    // Read data sampled at setup so it is stable through the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= STATUS_RESET;
        end else if (ce && setup_phase) begin
            prdata_q <= rdata_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 1'b0;
        end else if (ce && setup_phase) begin
            err_q <= err_d;
        end
    end

    // [RULE_09] only interrupt enable and clear registers accept writes
    assign enable_we = access_done && pwrite && hit_irq_enable;
    assign clear_we = access_done && pwrite && hit_irq_clear;

    irq_bank #(
        .W(EV_W)
    ) u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .set(events),
        .enable_we(enable_we),
        .clear_we(clear_we),
        .wdata(pwdata[EV_W-1:0]),
        .status_q(irq_status_q),
        .enable_q(irq_enable_q),
        .irq(irq)
    );

    assign prdata = prdata_q;
    assign pready = psel && penable && ce;
    assign pslverr = psel && penable && ce && err_q;

endmodule

//--- core/sys_status_pkg.sv
package sys_status_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int WORD_W = 10;

    // Printed offsets are word indices; byte address is four times the index
    localparam logic [7:0] STATUS1_IDX = 8'hE4;
    localparam logic [7:0] STATUS2_IDX = 8'hEA;
    localparam logic [7:0] STATUS3_IDX = 8'hEC;
    localparam logic [7:0] IRQ_STATUS_IDX = 8'hF0;
    localparam logic [7:0] IRQ_ENABLE_IDX = 8'hF1;
    localparam logic [7:0] IRQ_CLEAR_IDX = 8'hF2;

    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

    localparam int VOLT_LSB = 16;
    localparam int VOLT_W = 16;
    localparam int SPEED_CMD_LSB = 1;
    localparam int SPEED_CMD_W = 15;
    localparam int SERIAL_ENTRY_BIT = 0;
    localparam int STATE_LSB = 28;
    localparam int STATE_W = 4;
    localparam int SELF_TEST_BIT = 17;
    localparam int MOTOR_SPEED_LSB = 0;
    localparam int MOTOR_SPEED_W = 16;

    localparam int EV_W = 5;
    localparam int EV_SERIAL_ENTRY = 0;
    localparam int EV_SELF_TEST_FAIL = 1;
    localparam int EV_STATE_CHANGE = 2;
    localparam int EV_FAULT_ENTRY = 3;
    localparam int EV_INVALID_STATE = 4;

    typedef enum logic [3:0] {
        ST_SYSTEM_IDLE = 4'h0,
        ST_START = 4'h1,
        ST_RUN = 4'h2,
        ST_INIT = 4'h3,
        ST_INITIAL_POSITION_DETECT_PHASE = 4'h4,
        ST_ALIGN = 4'h5,
        ST_MOTOR_IDLE = 4'h6,
        ST_STOP = 4'h7,
        ST_FAULT = 4'h8,
        ST_DIRECTION = 4'h9,
        ST_SENSOR_ALIGN_PHASE = 4'hA,
        ST_CODE_B = 4'hB,
        ST_COASTING_PHASE = 4'hC,
        ST_BRAKING_PHASE = 4'hD,
        ST_CODE_E = 4'hE,
        ST_NOT_APPLICABLE = 4'hF
    } ctrl_state_t;

    typedef enum logic [2:0] {
        APB_IDLE = 3'b001,
        APB_SETUP = 3'b010,
        APB_ACCESS = 3'b100
    } apb_state_t;

endpackage

//--- core/field_reg.sv
`timescale 1ns/1ps
module field_reg #(
    parameter int W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else if (load) begin
            q <= d;
        end
    end
endmodule

//--- core/irq_bank.sv
`timescale 1ns/1ps
module irq_bank #(
    parameter int W = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [W-1:0] set,
    input wire logic enable_we,
    input wire logic clear_we,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] status_q,
    output logic [W-1:0] enable_q,
    output logic irq
);
    logic [W-1:0] status_d;

    // Set wins over a clear in the same cycle
    always_comb begin
        status_d = status_q;
        if (clear_we) begin
            status_d = status_d & ~wdata;
        end
        status_d = status_d | set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= '0;
        end else if (ce) begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= '0;
        end else if (ce && enable_we) begin
            enable_q <= wdata;
        end
    end

    assign irq = |(status_q & enable_q);
endmodule

//--- tb/sys_status_monitor.sv
`timescale 1ns/1ps
module sys_status_monitor
    import sys_status_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [VOLT_W-1:0] input_voltage_reading,
    input wire logic [SPEED_CMD_W-1:0] speed_command,
    input wire logic serial_entry_by_pins,
    input wire logic [STATE_W-1:0] control_state,
    input wire logic self_test_fail_flag,
    input wire logic [MOTOR_SPEED_W-1:0] motor_speed
);
    logic [STATE_W-1:0] state_shown;
    // Undocumented codes B and E read back as not applicable
    assign state_shown = (control_state == ST_CODE_B || control_state == ST_CODE_E) ?
        ST_NOT_APPLICABLE : control_state;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence rd(logic [ADDR_W-1:0] a);
        psel && !penable && !pwrite && paddr == a ##1 pready;
    endsequence
    // Field shows a source that was steady over the read
    property p_fld(logic [ADDR_W-1:0] a, logic [15:0] got, logic [15:0] src);
        rd(a) ##0 ($past(src, 2) == $past(src) && $past(presetn, 2)) |-> got == $past(src, 2);
    endproperty
    a_volt_field: assert property (p_fld(12'h390, prdata[31:16], input_voltage_reading))
        else $error("voltage field wrong");
    a_cmd_field: assert property (p_fld(12'h390, {1'b0, prdata[15:1]}, {1'b0, speed_command}))
        else $error("speed command field wrong");
    a_entry_bit: assert property (p_fld(12'h390, {15'h0000, prdata[0]}, {15'h0000, serial_entry_by_pins}))
        else $error("serial entry bit wrong");
    a_state_field: assert property (p_fld(12'h3A8, {12'h000, prdata[31:28]}, {12'h000, state_shown}))
        else $error("state field wrong");
    a_stl_bit: assert property (p_fld(12'h3A8, {15'h0000, prdata[17]}, {15'h0000, self_test_fail_flag}))
        else $error("self test bit wrong");
    a_speed_field: assert property (p_fld(12'h3A8, prdata[15:0], motor_speed))
        else $error("motor speed field wrong");
    a_resv_zero: assert property (rd(12'h3A8) |-> prdata[27:18] == 10'h000 && !prdata[16])
        else $error("reserved bits not zero");
    a_ready_now: assert property (psel && !penable ##1 psel && penable && ce |-> pready)
        else $error("access not answered at once");
    a_bad_addr: assert property (pready && paddr == 12'h004 |-> pslverr)
        else $error("unmapped access without error");
endmodule

//--- tb/test_system_status_registers.sv
`timescale 1ns/1ps
module test_system_status_registers
    import sys_status_pkg::*;
;
    logic pclk = 0;
    logic presetn = 0;
    logic ce = 1;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic stl = 0;
    logic serial = 0;
    logic irq;
    logic pready;
    logic pslverr;
    logic e;
    logic [ADDR_W-1:0] paddr = 0;
    logic [DATA_W-1:0] pwdata = 0;
    logic [DATA_W-1:0] prdata;
    logic [DATA_W-1:0] cpw = 0;
    logic [DATA_W-1:0] r;
    logic [15:0] volt = 0;
    logic [15:0] speed = 0;
    logic [14:0] cmd = 0;
    logic [3:0] state = 0;
    logic [3:0] xs;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;

    system_status_registers dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .input_voltage_reading(volt), .speed_command(cmd), .serial_entry_by_pins(serial),
        .control_state(state), .self_test_fail_flag(stl), .motor_speed(speed), .current_power_word(cpw),
        .irq(irq));

    always #2.5 pclk = ~pclk;

    task test_done;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            test_done();
        end
    end

    task chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, g, x);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 32'h0000_0000);
        chk(r, x);
    endtask

    task settle;
        repeat (3) @(posedge pclk);
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        rdc(12'h390, 32'h0000_0000);
        rdc(12'h3A8, 32'h0000_0000);
        rdc(12'h3B0, 32'h0000_0000);
        @(posedge pclk);
        volt <= 16'hABCD;
        cmd <= 15'h7FFF;
        serial <= 1;
        cpw <= 32'h1234_5678;
        settle();
        rdc(12'h390, 32'hABCD_FFFF);
        apb(1, 12'h390, 32'h0000_0000);
        chk({31'h0000_0000, e}, 32'h0000_0000);
        rdc(12'h390, 32'hABCD_FFFF);
        rdc(12'h3B0, 32'h1234_5678);
        volt <= 16'h0001;
        cmd <= 15'h4000;
        serial <= 0;
        settle();
        rdc(12'h390, 32'h0001_8000);
        for (int i = 0; i < 16; i++) begin
            xs = (i == 11 || i == 14) ? ST_NOT_APPLICABLE : i[3:0];
            state <= i[3:0];
            stl <= i[0];
            speed <= {i[3:0], 12'h5A5};
            settle();
            rdc(12'h3A8, {xs, 10'h000, i[0], 1'b0, i[3:0], 12'h5A5});
        end
        apb(0, 12'h004, 32'h0000_0000);
        chk({31'h0000_0000, e}, 32'h0000_0001);
        // Earlier pin rise raised the serial entry bit, the loop raised the other event bits
        rdc(12'h3C0, 32'h0000_001F);
        // Masked, then enabled, then cleared interrupt
        apb(1, 12'h3C8, 32'h0000_001F);
        serial <= 1;
        settle();
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rdc(12'h3C0, 32'h0000_0001);
        apb(1, 12'h3C4, 32'h0000_0001);
        @(posedge pclk);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        rdc(12'h3C4, 32'h0000_0001);
        apb(1, 12'h3C8, 32'h0000_0001);
        @(posedge pclk);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        rdc(12'h3C0, 32'h0000_0000);
        // Pin pulse while frozen is never seen
        ce <= 0;
        serial <= 0;
        settle();
        serial <= 1;
        settle();
        ce <= 1;
        settle();
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        test_done();
    end
endmodule

bind system_status_registers sys_status_monitor u_mon (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_voltage_reading(input_voltage_reading), .speed_command(speed_command),
    .serial_entry_by_pins(serial_entry_by_pins), .control_state(control_state),
    .self_test_fail_flag(self_test_fail_flag), .motor_speed(motor_speed));
